// file: src/rcp_cfg.svh
// constants for the serial command parser
`ifndef RCP_CFG_SVH
`define RCP_CFG_SVH
`define RCP_CLK_HZ        100000000
`define RCP_BAUD_MIN      1200
`define RCP_BAUD_MAX      9600
// bit period in cycles at the fastest and slowest rates
`define RCP_BIT_FAST      (`RCP_CLK_HZ / `RCP_BAUD_MAX)
`define RCP_BIT_SLOW      (`RCP_CLK_HZ / `RCP_BAUD_MIN)
// accepted start-bit length, one eighth margin either way
`define RCP_BIT_MIN       (`RCP_BIT_FAST - `RCP_BIT_FAST / 8)
`define RCP_BIT_MAX       (`RCP_BIT_SLOW + `RCP_BIT_SLOW / 8)
`define RCP_CNT_W         17
`define RCP_CHAR_BITS     12'h00A
`define RCP_IDLE_BITS     12'h014
`define RCP_CH_START      8'h21
`define RCP_CH_A          8'h41
`define RCP_CH_C          8'h43
`define RCP_CH_D          8'h44
`define RCP_CH_O          8'h4F
`define RCP_CH_R          8'h52
`define RCP_CH_S          8'h53
`define RCP_ADDR_RST      8'h30
`define RCP_TURN_RST      8'h01
`define RCP_DIR_RST       16'h0000
`define RCP_PWRUP_RST     16'h0000
`endif

// file: src/rcp_pkg.sv
// types for the serial command parser
package rcp_pkg;
  typedef enum logic [2:0] {
    ST_HUNT = 3'h0,
    ST_MEAS = 3'h1,
    ST_IDLE = 3'h2,
    ST_RXD  = 3'h3,
    ST_EXEC = 3'h4,
    ST_TURN = 3'h5,
    ST_TX   = 3'h6
  } rcp_state_t;
  typedef enum logic [2:0] {
    CMD_BAD              = 3'h0,
    CMD_READ_LINES       = 3'h1,
    CMD_SET_OUTPUTS      = 3'h2,
    CMD_SET_ADDRESS      = 3'h3,
    CMD_SET_TURNAROUND   = 3'h4,
    CMD_DEFINE_DIRECTION = 3'h5,
    CMD_SET_POWERUP      = 3'h6,
    CMD_READ_CONFIG      = 3'h7
  } rcp_cmd_t;
endpackage

// file: src/rcp_parser.sv
// serial command interpreter for a sixteen-line digital i/o node
// Contract
// - the bit rate is measured from the start bit of each frame, 1200 to 9600.
// - every character is 8 data bits, 1 stop bit, no parity, both ways.
// - works on a looped two-wire bus or a four-wire bus shared by nodes.
// - a frame is start, address, two command letters, then 0 to 2 data bytes.
// - start is 21h and letters A C D O R S are 41h 43h 44h 4Fh 52h 53h.
// - data and address bytes are raw values 0 to 255, any value legal.
// - the address byte is compared by numeric code.
// - read-lines replies two bytes; set-outputs takes two and is silent.
// - five configuration commands with one, two or no data bytes.
// - read-configuration replies directions, power-up states, address, delay.
// - only frames carrying the node's own address are acted on.
// - sixteen-line values travel high byte (lines 15..8) first.
// - a reply waits the turn-around count times ten bit periods.
// - set-outputs leaves lines defined as inputs untouched.
`timescale 1ns/1ps
`default_nettype none
`include "rcp_cfg.svh"
module rcp_parser #(
  parameter int BIT_MIN_CYC = `RCP_BIT_MIN,
  parameter int BIT_MAX_CYC = `RCP_BIT_MAX
) (
  input  wire logic        CLK,       // 100 MHz clock
  input  wire logic        RST,       // synchronous reset, high
  input  wire logic        RX_LINE,   // receive data, idle high
  input  wire logic [15:0] IO_IN,     // sensed i/o line levels
  output logic             TX_LINE_A, // transmit data, inverted leg
  output logic             TX_LINE_B, // transmit data, true leg
  output logic             TX_EN,     // line driver enable
  output logic      [15:0] IO_OUT,    // output line levels
  output logic      [15:0] IO_DIR,    // 1 = line is an output
  output logic      [15:0] IO_PWRUP,  // stored power-up states
  output logic       [7:0] NODE_ADDR, // stored node address
  output logic       [7:0] TURN_DLY   // stored turn-around count
);
  localparam int W = `RCP_CNT_W;
  localparam logic [W-1:0] BMIN = W'(BIT_MIN_CYC);
  localparam logic [W-1:0] BMAX = W'(BIT_MAX_CYC);
  function automatic rcp_pkg::rcp_cmd_t decode(input logic [7:0] c1,
                                               input logic [7:0] c2);
    rcp_pkg::rcp_cmd_t c = rcp_pkg::CMD_BAD;
    if (c1 == `RCP_CH_R && c2 == `RCP_CH_D) c = rcp_pkg::CMD_READ_LINES;
    if (c1 == `RCP_CH_R && c2 == `RCP_CH_C) c = rcp_pkg::CMD_READ_CONFIG;
    if (c1 == `RCP_CH_S && c2 == `RCP_CH_O) c = rcp_pkg::CMD_SET_OUTPUTS;
    if (c1 == `RCP_CH_S && c2 == `RCP_CH_A) c = rcp_pkg::CMD_SET_ADDRESS;
    if (c1 == `RCP_CH_S && c2 == `RCP_CH_C) c = rcp_pkg::CMD_SET_TURNAROUND;
    if (c1 == `RCP_CH_S && c2 == `RCP_CH_D) c = rcp_pkg::CMD_DEFINE_DIRECTION;
    if (c1 == `RCP_CH_S && c2 == `RCP_CH_S) c = rcp_pkg::CMD_SET_POWERUP;
    return c;
  endfunction
  function automatic logic [1:0] nargs(input rcp_pkg::rcp_cmd_t c);
    unique case (c)
      rcp_pkg::CMD_SET_ADDRESS,
      rcp_pkg::CMD_SET_TURNAROUND:   nargs = 2'h1;
      rcp_pkg::CMD_SET_OUTPUTS,
      rcp_pkg::CMD_DEFINE_DIRECTION,
      rcp_pkg::CMD_SET_POWERUP:      nargs = 2'h2;
      default:                       nargs = 2'h0;
    endcase
  endfunction
  rcp_pkg::rcp_state_t state_q;
  rcp_pkg::rcp_cmd_t   cmd_q;
  logic          rx_m_q, rx_s_q, rx_p_q;
  logic [15:0]   io_m_q, io_s_q;
  logic [W-1:0]  cnt_q, bit_len_q;
  logic [3:0]    bits_q;
  logic [2:0]    field_q, rep_n_q;
  logic [11:0]   wait_q;
  logic [7:0]    sh_q, c1_q, a1_q, addr_q, turn_q;
  logic [15:0]   dir_q, pw_q, out_q;
  logic [8:0]    txs_q;
  logic          txd_q, txa_q, en_q;
  logic [7:0]    rep_q [0:5];
  wire tick     = (cnt_q == '0);
  wire rx_fall  = rx_p_q & ~rx_s_q;
  wire [W-1:0] meas_len = cnt_q + W'(1);
  wire len_ok   = (meas_len >= BMIN) && (meas_len <= BMAX);
  wire [7:0] rx_byte = {rx_s_q, sh_q[7:1]};
  wire rcp_pkg::rcp_cmd_t cmd_w = decode(c1_q, sh_q);
  wire [1:0] cmd_args = nargs(cmd_q);
  wire [15:0] so_val  = (out_q & ~dir_q) | ({a1_q, sh_q} & dir_q);
  wire [11:0] turn_w  = 12'(turn_q) * `RCP_CHAR_BITS;
  wire [W-1:0] reload = bit_len_q - W'(1);
  // two-flop synchronisers; edge detect compares the second stage with a third flop
  always_ff @(posedge CLK) begin
    {rx_p_q, rx_s_q, rx_m_q} <= {rx_s_q, rx_m_q, RX_LINE};
    {io_s_q, io_m_q}         <= {io_m_q, IO_IN};
  end
  // working registers are loaded before use, so only state, settings and the transmit line flops reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q   <= rcp_pkg::ST_HUNT;
      addr_q    <= `RCP_ADDR_RST;
      turn_q    <= `RCP_TURN_RST;
      dir_q     <= `RCP_DIR_RST;
      pw_q      <= `RCP_PWRUP_RST;
      out_q     <= `RCP_PWRUP_RST;
      txd_q     <= 1'b1;
      txa_q     <= 1'b0;
      en_q      <= 1'b0;
    end else begin
      unique case (state_q)
        rcp_pkg::ST_HUNT: begin
          field_q <= 3'h0;
          cnt_q   <= '0;
          if (rx_fall) state_q <= rcp_pkg::ST_MEAS;
        end
        rcp_pkg::ST_MEAS: begin
          // start bit of 21h is followed by a one, so its low time is one bit
          cnt_q <= cnt_q + W'(1);
          if (rx_s_q && len_ok) begin
            bit_len_q <= meas_len;
            cnt_q     <= meas_len >> 1;
            bits_q    <= 4'h1;
            state_q   <= rcp_pkg::ST_RXD;
          end else if (rx_s_q || cnt_q > BMAX) begin
            state_q <= rcp_pkg::ST_HUNT;
          end
        end
        rcp_pkg::ST_IDLE: begin
          if (rx_fall) begin
            cnt_q   <= bit_len_q >> 1;
            bits_q  <= 4'h0;
            state_q <= rcp_pkg::ST_RXD;
          end else if (tick) begin
            cnt_q  <= reload;
            wait_q <= wait_q + 12'h001;
            // a stalled frame is dropped after twenty-one idle bit times
            if (wait_q == `RCP_IDLE_BITS) state_q <= rcp_pkg::ST_HUNT;
          end else begin
            cnt_q <= cnt_q - W'(1);
          end
        end
        rcp_pkg::ST_RXD: begin
          if (!tick) begin
            cnt_q <= cnt_q - W'(1);
          end else begin
            cnt_q  <= reload;
            bits_q <= bits_q + 4'h1;
            wait_q <= 12'h000;
            if (bits_q == 4'h0) begin
              if (rx_s_q) state_q <= rcp_pkg::ST_IDLE;
            end else if (bits_q != 4'h9) begin
              sh_q <= rx_byte;
            end else if (!rx_s_q) begin
              state_q <= rcp_pkg::ST_HUNT;
            end else begin
              state_q <= rcp_pkg::ST_IDLE;
              field_q <= field_q + 3'h1;
              unique case (field_q)
                3'h0: if (sh_q != `RCP_CH_START)
                  state_q <= rcp_pkg::ST_HUNT;
                3'h1: if (sh_q != addr_q)
                  state_q <= rcp_pkg::ST_HUNT;
                3'h2: c1_q <= sh_q;
                3'h3: begin
                  cmd_q <= cmd_w;
                  if (cmd_w == rcp_pkg::CMD_BAD)
                    state_q <= rcp_pkg::ST_HUNT;
                  else if (nargs(cmd_w) == 2'h0)
                    state_q <= rcp_pkg::ST_EXEC;
                end
                3'h4: begin
                  a1_q <= sh_q;
                  if (cmd_args == 2'h1) state_q <= rcp_pkg::ST_EXEC;
                end
                3'h5: state_q <= rcp_pkg::ST_EXEC;
                default: state_q <= rcp_pkg::ST_HUNT;
              endcase
            end
          end
        end
        rcp_pkg::ST_EXEC: begin
          // argument bytes are raw; single-argument value sits in sh_q
          state_q <= rcp_pkg::ST_HUNT;
          wait_q  <= turn_w;
          cnt_q   <= reload;
          unique case (cmd_q)
            rcp_pkg::CMD_SET_OUTPUTS:      out_q  <= so_val;
            rcp_pkg::CMD_SET_ADDRESS:      addr_q <= sh_q;
            rcp_pkg::CMD_SET_TURNAROUND:   turn_q <= sh_q;
            rcp_pkg::CMD_DEFINE_DIRECTION: dir_q  <= {a1_q, sh_q};
            rcp_pkg::CMD_SET_POWERUP:      pw_q   <= {a1_q, sh_q};
            rcp_pkg::CMD_READ_LINES: begin
              rep_q[0] <= io_s_q[15:8];
              rep_q[1] <= io_s_q[7:0];
              rep_n_q  <= 3'h2;
              state_q  <= rcp_pkg::ST_TURN;
            end
            rcp_pkg::CMD_READ_CONFIG: begin
              rep_q[0] <= dir_q[15:8];
              rep_q[1] <= dir_q[7:0];
              rep_q[2] <= pw_q[15:8];
              rep_q[3] <= pw_q[7:0];
              rep_q[4] <= addr_q;
              rep_q[5] <= turn_q;
              rep_n_q  <= 3'h6;
              state_q  <= rcp_pkg::ST_TURN;
            end
            default: state_q <= rcp_pkg::ST_HUNT;
          endcase
        end
        rcp_pkg::ST_TURN: begin
          if (wait_q == 12'h000) begin
            state_q <= rcp_pkg::ST_TX;
            en_q    <= 1'b1;
            txd_q   <= 1'b0;
            txa_q   <= 1'b1;
            txs_q   <= {1'b1, rep_q[0]};
            field_q <= 3'h0;
            bits_q  <= 4'h0;
            cnt_q   <= reload;
          end else if (tick) begin
            wait_q <= wait_q - 12'h001;
            cnt_q  <= reload;
          end else begin
            cnt_q <= cnt_q - W'(1);
          end
        end
        rcp_pkg::ST_TX: begin
          // receiver is not looked at here, so a looped two-wire echo is lost
          if (!tick) begin
            cnt_q <= cnt_q - W'(1);
          end else begin
            cnt_q <= reload;
            if (bits_q != 4'h9) begin
              txd_q  <= txs_q[0];
              txa_q  <= ~txs_q[0];
              txs_q  <= {1'b1, txs_q[8:1]};
              bits_q <= bits_q + 4'h1;
            end else if (field_q == rep_n_q - 3'h1) begin
              en_q    <= 1'b0;
              txd_q   <= 1'b1;
              txa_q   <= 1'b0;
              state_q <= rcp_pkg::ST_HUNT;
            end else begin
              field_q <= field_q + 3'h1;
              txd_q   <= 1'b0;
              txa_q   <= 1'b1;
              txs_q   <= {1'b1, rep_q[field_q + 3'h1]};
              bits_q  <= 4'h0;
            end
          end
        end
        default: state_q <= rcp_pkg::ST_HUNT;
      endcase
    end
  end

  assign TX_LINE_A = txa_q;
  assign TX_LINE_B = txd_q;
  assign TX_EN     = en_q;
  assign IO_OUT    = out_q;
  assign IO_DIR    = dir_q;
  assign IO_PWRUP  = pw_q;
  assign NODE_ADDR = addr_q;
  assign TURN_DLY  = turn_q;
  sequence s_tx_begin;
    $rose(TX_EN);
  endsequence
  sequence s_tx_end;
    $fell(TX_EN);
  endsequence

  a_driver_gate: assert property (@(posedge CLK) disable iff (RST)
    TX_EN == (state_q == rcp_pkg::ST_TX))
    else $error("driver enable outside reply");
  a_diff_legs: assert property (@(posedge CLK) disable iff (RST)
    TX_LINE_A == !TX_LINE_B)
    else $error("transmit legs not complementary");
  a_start_low: assert property (@(posedge CLK) disable iff (RST)
    s_tx_begin |-> !TX_LINE_B)
    else $error("reply does not open with a start bit");
  a_stop_release: assert property (@(posedge CLK) disable iff (RST)
    s_tx_end |-> TX_LINE_B && $past(TX_LINE_B))
    else $error("driver released before stop bit");
  a_input_hold: assert property (@(posedge CLK) disable iff (RST)
    IO_DIR == $past(IO_DIR) |-> ((IO_OUT ^ $past(IO_OUT)) & ~IO_DIR) == 16'h0)
    else $error("input line changed by set-outputs");
  a_baud_lock: assert property (@(posedge CLK) disable iff (RST)
    state_q == rcp_pkg::ST_MEAS && rx_s_q && len_ok
      |=> state_q == rcp_pkg::ST_RXD && bit_len_q >= BMIN
          && bit_len_q <= BMAX)
    else $error("baud lock outside range");
  a_addr_match: assert property (@(posedge CLK) disable iff (RST)
    state_q == rcp_pkg::ST_RXD && tick && bits_q == 4'h9 && rx_s_q
      && field_q == 3'h1 && sh_q != addr_q |=> state_q == rcp_pkg::ST_HUNT)
    else $error("foreign address not dropped");
  a_turn_wait: assert property (@(posedge CLK) disable iff (RST)
    state_q == rcp_pkg::ST_TURN && wait_q != 12'h000 |=> !TX_EN)
    else $error("reply before turn-around elapsed");
  a_reply_len: assert property (@(posedge CLK) disable iff (RST)
    state_q == rcp_pkg::ST_EXEC && cmd_q == rcp_pkg::CMD_READ_CONFIG
      |=> rep_n_q == 3'h6 && state_q == rcp_pkg::ST_TURN)
    else $error("configuration reply not six bytes");
endmodule
`default_nettype wire

// file: dv/rcp_host.sv
// host serial port model sitting on the far end of the bus
`timescale 1ns/1ps
`default_nettype none
module rcp_host (
  input  wire logic clk,   // bench clock
  output logic      line,  // host transmit, idle high
  input  wire logic tx_a,  // node inverted leg
  input  wire logic tx_b,  // node true leg
  input  wire logic tx_en  // node driver enable
);
  int         bit_len  = 32;
  int         cyc      = 0;
  int         mark_cyc = 0;
  int         n_bad    = 0;
  int         g;
  logic [7:0] b;
  logic [7:0] rx_q[$];
  int         gap_q[$];

  initial line = 1'b1;
  always @(posedge clk) cyc <= cyc + 1;

  // one start bit, 8 data bits lsb first, one stop bit, no parity
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line = f[i];
      repeat (bit_len / 2) @(negedge clk);
      if (i == 9) mark_cyc = cyc;
      repeat (bit_len - bit_len / 2) @(negedge clk);
    end
  endtask

  // the long idle gap lets the node drop any half-taken frame
  task automatic send_frame(input logic [7:0] q[$]);
    @(negedge clk);
    line = 1'b1;
    repeat (24 * bit_len) @(negedge clk);
    foreach (q[i]) send_byte(q[i]);
  endtask

  // 4-wire hookup: the node's reply is not looped back to its input
  initial forever begin
    @(negedge clk);
    if (tx_en && !tx_b) begin
      g = cyc - mark_cyc;
      repeat (bit_len / 2) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_len) @(negedge clk);
        if (tx_a !== ~tx_b || tx_en !== 1'b1) n_bad++;
        if (i < 8) b[i] = tx_b;
        else if (tx_b !== 1'b1) n_bad++;
      end
      // reply bytes run back to back: resync on each new start edge
      repeat (bit_len / 2 - 2) @(negedge clk);
      for (int k = 0; k < 5 && tx_en && tx_b; k++) @(negedge clk);
      if (tx_en && tx_b) n_bad++;
      rx_q.push_back(b);
      gap_q.push_back(g);
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the serial command parser
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CLK   = 1'b0;
  logic        RST   = 1'b1;
  logic [15:0] IO_IN = 16'hC852;
  wire logic   RX_LINE;
  wire logic   TX_LINE_A, TX_LINE_B, TX_EN;
  wire logic [15:0] IO_OUT, IO_DIR, IO_PWRUP;
  wire logic [7:0]  NODE_ADDR, TURN_DLY;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          tick        = 0;

  always #5 CLK = ~CLK;

  rcp_host host (.clk(CLK), .line(RX_LINE), .tx_a(TX_LINE_A),
                 .tx_b(TX_LINE_B), .tx_en(TX_EN));

  // short start-bit limits admit bit periods of 8 to 200 cycles, so the bench can run at 32 and 48
  rcp_parser #(.BIT_MIN_CYC(8), .BIT_MAX_CYC(200)) DUT (
    .CLK(CLK), .RST(RST), .RX_LINE(RX_LINE), .IO_IN(IO_IN),
    .TX_LINE_A(TX_LINE_A), .TX_LINE_B(TX_LINE_B), .TX_EN(TX_EN),
    .IO_OUT(IO_OUT), .IO_DIR(IO_DIR), .IO_PWRUP(IO_PWRUP),
    .NODE_ADDR(NODE_ADDR), .TURN_DLY(TURN_DLY));

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_win(input string nm, input int lo, input int hi,
                         input int s);
    checks_done++;
    if (s < lo || s > hi) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  // turn-around is reckoned from the middle of our last stop bit
  task automatic expect_reply(input logic [7:0] e[$], input int t);
    int lo;
    lo = t * 10 * host.bit_len;
    for (int i = 0; i < 20000 && host.rx_q.size() < e.size(); i++)
      @(negedge CLK);
    chk("reply count", 16'(e.size()), 16'(host.rx_q.size()));
    foreach (e[i]) chk("reply byte", {8'h00, e[i]}, {8'h00, host.rx_q[i]});
    if (host.gap_q.size() > 0)
      chk_win("turn-around", lo, lo + 16, host.gap_q[0]);
    host.rx_q.delete();
    host.gap_q.delete();
  endtask

  // a hang counts as a mismatch
  always @(posedge CLK) begin
    tick <= tick + 1;
    if (tick == 70000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    chk("addr", 16'h0030, {8'h00, NODE_ADDR});
    chk("turn", 16'h0001, {8'h00, TURN_DLY});
    chk("dir", 16'h0000, IO_DIR);
    chk("idle", 16'h0002, {13'h0000, TX_EN, TX_LINE_B, TX_LINE_A});
    host.send_frame({8'h21, 8'h30, 8'h52, 8'h44});
    expect_reply({8'hC8, 8'h52}, 1);
    host.send_frame({8'h21, 8'h30, 8'h53, 8'h44, 8'hFF, 8'h0F});
    host.send_frame({8'h21, 8'h30, 8'h53, 8'h4F, 8'h55, 8'h41});
    repeat (4) @(negedge CLK);
    chk("dir", 16'hFF0F, IO_DIR);
    chk("out", 16'h5501, IO_OUT);
    host.send_frame({8'h21, 8'h30, 8'h53, 8'h53, 8'h12, 8'h34});
    host.send_frame({8'h21, 8'h31, 8'h53, 8'h4F, 8'h00, 8'h00});
    host.send_frame({8'h21, 8'h30, 8'h43, 8'h41});
    host.send_frame({8'h21, 8'h30, 8'h53, 8'h43, 8'h00});
    repeat (4) @(negedge CLK);
    chk("pwrup", 16'h1234, IO_PWRUP);
    chk("out", 16'h5501, IO_OUT);
    chk("turn", 16'h0000, {8'h00, TURN_DLY});
    host.send_frame({8'h21, 8'h30, 8'h52, 8'h43});
    expect_reply({8'hFF, 8'h0F, 8'h12, 8'h34, 8'h30, 8'h00}, 0);
    host.send_frame({8'h21, 8'h30, 8'h53, 8'h41, 8'h00});
    repeat (4) @(negedge CLK);
    chk("addr", 16'h0000, {8'h00, NODE_ADDR});
    IO_IN = 16'h8001;
    host.send_frame({8'h21, 8'h30, 8'h52, 8'h44});
    host.bit_len = 48;
    host.send_frame({8'h21, 8'h00, 8'h52, 8'h44});
    expect_reply({8'h80, 8'h01}, 0);
    chk("line form", 16'h0000, 16'(host.n_bad));
    give_verdict();
  end
endmodule
`default_nettype wire
